//--- hdl/ldc_pkg.sv
// constants, types and helpers shared by the led dimming controller
package ldc_pkg;
    // base clock and derived timing
    localparam int CLK_HZ       = 25_000_000;
    localparam int MIX_SLOW_HZ  = 200;
    localparam int MIX_FAST_HZ  = 23_000;
    localparam int MIX_SLOW_CYC = CLK_HZ / MIX_SLOW_HZ;
    localparam int MIX_FAST_CYC = CLK_HZ / MIX_FAST_HZ;
    localparam int DEEP_ON_NS   = 7_000;
    localparam int DEEP_ON_CYC  = DEEP_ON_NS / (1_000_000_000 / CLK_HZ);
    localparam int STARTUP_US   = 500;
    localparam int STARTUP_CYC  = STARTUP_US * (CLK_HZ / 1_000_000);
    // 1024 duty steps resolve well past a 200 to 1 range
    localparam int DUTY_W       = 10;
    localparam int DUTY_FS      = 1 << DUTY_W;
    localparam int LOW_DUTY_PCT = 10;
    localparam int N_CH         = 6;
    // register indices; the byte address is four times the index
    localparam logic [7:0] CFG0_IDX  = 8'h00;
    localparam logic [7:0] CFG1_IDX  = 8'h01;
    localparam logic [7:0] STAT_IDX  = 8'h04;
    localparam logic [7:0] CFG0_ADDR = CFG0_IDX << 2;
    localparam logic [7:0] CFG1_ADDR = CFG1_IDX << 2;
    localparam logic [7:0] STAT_ADDR = STAT_IDX << 2;
    // config fields, writable masks and values after reset
    localparam int MODE_LSB      = 5;
    localparam int MIXTP_BIT     = 4;
    localparam int MIX_OUTPUT_FREQ_SELECT_BIT     = 3;
    localparam int PSE_BIT       = 7;
    localparam int CHCNT_LSB     = 0;
    localparam logic [7:0] CFG0_MASK = 8'h78;
    localparam logic [7:0] CFG1_MASK = 8'h87;
    localparam logic [7:0] CFG0_RST  = 8'h00;
    localparam logic [7:0] CFG1_RST  = 8'h00;
    // status fields
    localparam int ST_DUTY_LSB   = 0;
    localparam int ST_MODE_LSB   = 12;
    localparam int ST_START_BIT  = 14;
    localparam int ST_UNUSED_LSB = 16;

    typedef enum logic [1:0] {
        LDC_MIX    = 2'b00,
        LDC_DIRECT = 2'b01,
        LDC_ANALOG = 2'b10
    } ldc_mode_type;

    // 65536 / n, used to split a period into n equal phases
    function automatic logic [16:0] ldc_recip(input logic [2:0] n);
        unique case (n)
            3'h1: ldc_recip = 17'h10000;
            3'h2: ldc_recip = 17'h08000;
            3'h3: ldc_recip = 17'h05555;
            3'h4: ldc_recip = 17'h04000;
            3'h5: ldc_recip = 17'h03333;
            3'h6: ldc_recip = 17'h02aab;
            default: ldc_recip = 17'h00000;
        endcase
    endfunction

    function automatic logic [2:0] ldc_popcount(input logic [5:0] m);
        ldc_popcount = 3'(m[0]) + 3'(m[1]) + 3'(m[2]) + 3'(m[3])
                     + 3'(m[4]) + 3'(m[5]);
    endfunction
endpackage

//--- hdl/ldc_duty_meter.sv
// dimming input duty meter with a serial long divider
module ldc_duty_meter import ldc_pkg::*; #(
    parameter int CNT_W = 20
) (
    input  wire logic              clk,      // system clock
    input  wire logic              rst,      // sync reset, high
    input  wire logic              pwm,      // synchronised dimming input
    output logic [DUTY_W-1:0]      duty,     // duty, full scale 1024
    output logic [CNT_W-1:0]       high_cyc, // last measured high time
    output logic [CNT_W-1:0]       per_cyc,  // last measured period
    output logic                   rise      // pulse on each rising edge
);
    typedef struct packed {
        logic              prev;
        logic [CNT_W-1:0]  cnt;
        logic [CNT_W-1:0]  hi;
        logic [CNT_W-1:0]  hiq;
        logic [CNT_W-1:0]  per;
        logic [CNT_W:0]    rem;
        logic [DUTY_W-1:0] quo;
        logic [3:0]        bits;
        logic [DUTY_W-1:0] duty;
        logic              rise;
    } ldc_meter_type;

    localparam logic [CNT_W-1:0] CMAX = '1;
    ldc_meter_type q;
    ldc_meter_type d;

    // counting, edge capture and one quotient bit per cycle
    always_comb begin
        logic [CNT_W:0] sh;
        d = q;
        sh = {q.rem[CNT_W-1:0], 1'b0};
        d.prev = pwm;
        d.rise = 1'b0;
        if (q.cnt != CMAX) begin
            d.cnt = q.cnt + 1'b1;
            if (pwm) begin
                d.hi = q.hi + 1'b1;
            end
        end else begin
            // no edge for ages: the input is a steady level
            d.duty = pwm ? '1 : '0;
            d.per = CMAX;
            d.hiq = pwm ? CMAX : '0;
        end
        if (q.bits != 4'h0) begin
            if (sh >= {1'b0, q.per}) begin
                d.rem = sh - {1'b0, q.per};
                d.quo = {q.quo[DUTY_W-2:0], 1'b1};
            end else begin
                d.rem = sh;
                d.quo = {q.quo[DUTY_W-2:0], 1'b0};
            end
            d.bits = q.bits - 1'b1;
            if (q.bits == 4'h1) begin
                d.duty = d.quo;
            end
        end
        // a new edge restarts the divider with fresh figures, unless the counter had saturated
        if (pwm && !q.prev) begin
            d.rise = 1'b1;
            d.cnt = CNT_W'(1);
            d.hi = CNT_W'(1);
            if (q.cnt != CMAX) begin
                d.per = q.cnt;
                d.hiq = q.hi;
                d.rem = {1'b0, q.hi};
                d.quo = '0;
                d.bits = 4'(DUTY_W);
            end
        end
    end

    // first period after reset is partial, so the counter starts saturated
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
            q.cnt <= '1;
        end else begin
            q <= d;
        end
    end

    assign duty = q.duty;
    assign high_cyc = q.hiq;
    assign per_cyc = q.per;
    assign rise = q.rise;
endmodule

//--- hdl/ldc_phase_gen.sv
// per-channel dimming windows, optionally spread over the period
module ldc_phase_gen import ldc_pkg::*; #(
    parameter int CNT_W = 20
) (
    input  wire logic             clk,      // system clock
    input  wire logic             rst,      // sync reset, high
    input  wire logic [CNT_W-1:0] period,   // dimming period in cycles
    input  wire logic [CNT_W-1:0] on_cyc,   // on time in cycles
    input  wire logic             restart,  // realign period start
    input  wire logic [2:0]       n_act,    // active channel count
    input  wire logic             shift_en, // spread channel phases
    output logic [N_CH-1:0]       chan_on   // per-channel on state
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [N_CH-1:0]  on;
    } ldc_phase_type;

    ldc_phase_type q;
    ldc_phase_type d;

    // channel k lags by k times period / n
    always_comb begin
        logic [CNT_W+16:0] prod;
        logic [CNT_W-1:0]  step;
        logic [CNT_W+2:0]  off;
        logic [CNT_W+2:0]  pos;
        off = '0;
        pos = '0;
        d = q;
        prod = period * ldc_recip(n_act);
        step = prod[16 +: CNT_W];
        if (restart || (q.cnt + 1'b1) >= period) begin
            d.cnt = '0;
        end else begin
            d.cnt = q.cnt + 1'b1;
        end
        for (int k = 0; k < N_CH; k++) begin
            off = shift_en ? 3'(k) * step : '0;
            if (off >= period) begin
                off = '0;
            end
            if (q.cnt >= off) begin
                pos = q.cnt - off;
            end else begin
                pos = q.cnt + period - off;
            end
            d.on[k] = pos < on_cyc;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign chan_on = q.on;
endmodule

//--- hdl/ldc_dimming_ctrl.sv
// led dimming controller: mode select, dimming, channels, apb registers

module ldc_dimming_ctrl import ldc_pkg::*; #(
    parameter int STARTUP_CYCLES = STARTUP_CYC,
    parameter int CNT_W          = 20
) (
    input  wire logic        clk,                 // 25 MHz clock
    input  wire logic        rst,                 // sync reset, high
    input  wire logic [7:0]  paddr,               // apb byte address
    input  wire logic        psel,                // apb select
    input  wire logic        penable,             // apb access phase
    input  wire logic        pwrite,              // apb write
    input  wire logic [31:0] pwdata,              // apb write data
    output logic      [31:0] prdata,              // apb read data
    output logic             pready,              // apb ready
    output logic             pslverr,             // apb error
    input  wire logic        dim_pwm_in,          // host dimming pwm pin
    input  wire logic        strap_low,           // mode strap below low band
    input  wire logic        strap_mid,           // mode strap in mid band
    input  wire logic        strap_high,          // mode strap in high band
    input  wire logic        serial_clock_phase_strap, // clock pin at tie level
    input  wire logic        serial_data_phase_strap,  // data pin at tie level
    input  wire logic [5:0]  led_channel_pin_low, // channel pin near ground
    output logic      [5:0]  led_channel_on,      // current source gates
    output logic      [9:0]  led_amplitude,       // current, 1023 = full
    output logic             vled_min_raise,      // raise led pin target
    output logic             vout_deep_dim,       // regulate at 93 pct ovp
    output logic      [1:0]  dimming_mode         // mode in effect
);
    typedef struct packed {
        logic [11:0] sy1;
        logic [11:0] sy2;
        logic [7:0]  cfg0;
        logic [7:0]  cfg1;
        logic [23:0] scnt;
        logic        started;
        logic [5:0]  unused;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [9:0]  amp;
        logic [5:0]  chan;
        logic        vled_hi;
        logic        deep;
        logic [1:0]  mode;
    } ldc_main_type;

    localparam logic [CNT_W-1:0] FULL_ON = '1;
    localparam logic [9:0]  AMP_FULL = 10'h3ff;
    localparam logic [16:0] LOW_LIM  = 17'(DUTY_FS * LOW_DUTY_PCT);

    ldc_main_type     q;
    ldc_main_type     d;
    logic [9:0]       duty;
    logic [CNT_W-1:0] m_high;
    logic [CNT_W-1:0] m_per;
    logic             m_rise;
    logic [5:0]       ph_on;
    logic [CNT_W-1:0] per_sel;
    logic [CNT_W-1:0] on_sel;
    logic             restart;
    logic             shift_en;
    logic [2:0]       n_act;

    // duty, high time and period of the synchronised input
    ldc_duty_meter #(
        .CNT_W    (CNT_W)
    ) u_meter (
        .clk      (clk),
        .rst      (rst),
        .pwm      (q.sy2[0]),
        .duty     (duty),
        .high_cyc (m_high),
        .per_cyc  (m_per),
        .rise     (m_rise)
    );

    ldc_phase_gen #(
        .CNT_W    (CNT_W)
    ) u_phase (
        .clk      (clk),
        .rst      (rst),
        .period   (per_sel),
        .on_cyc   (on_sel),
        .restart  (restart),
        .n_act    (n_act),
        .shift_en (shift_en),
        .chan_on  (ph_on)
    );

    always_comb begin
        ldc_mode_type      mode;
        logic [9:0]        tp;
        logic [10:0]       outduty;
        logic [CNT_W-1:0]  per_mix;
        logic [CNT_W+10:0] prod;
        logic              pwm_dim;
        logic [16:0]       d100;
        logic [2:0]        nch;
        logic [5:0]        en_mask;
        logic [5:0]        bits;
        logic              setup;
        logic              addr_ok;
        d = q;
        nch = 3'd0;
        mode = LDC_MIX;
        prod = '0;
        bits = '0;
        pwm_dim = 1'b0;
        restart = 1'b0;

        // pins cross into the clock domain through two flops
        d.sy1 = {led_channel_pin_low, serial_data_phase_strap,
                 serial_clock_phase_strap, strap_high, strap_mid,
                 strap_low, dim_pwm_in};
        d.sy2 = q.sy1;

        // strap bands win; a floating strap defers to the register
        if (q.sy2[1]) begin
            mode = LDC_MIX;
        end else if (q.sy2[2]) begin
            mode = LDC_DIRECT;
        end else if (q.sy2[3]) begin
            mode = LDC_ANALOG;
        end else begin
            unique case (q.cfg0[MODE_LSB +: 2])
                2'b01: mode = LDC_DIRECT;
                2'b10: mode = LDC_ANALOG;
                default: mode = LDC_MIX;
            endcase
        end
        d.mode = mode;

        // mix transfer point and output period come from config
        tp = q.cfg0[MIXTP_BIT] ? 10'(DUTY_FS / 8) : 10'(DUTY_FS / 4);
        outduty = q.cfg0[MIXTP_BIT] ? 11'({duty, 3'b000})
                                    : 11'({duty, 2'b00});
        per_mix = q.cfg0[MIX_OUTPUT_FREQ_SELECT_BIT] ? CNT_W'(MIX_FAST_CYC)
                                    : CNT_W'(MIX_SLOW_CYC);
        d100 = duty * 7'd100;
        d.vled_hi = 1'b0;

        unique case (mode)
            LDC_MIX: begin
                // mix runs its own period, ignoring the input's
                per_sel = per_mix;
                if (duty >= tp) begin
                    d.amp = duty;
                    on_sel = per_mix;
                end else begin
                    d.amp = tp;
                    prod = per_mix * outduty;
                    on_sel = prod[DUTY_W +: CNT_W];
                    pwm_dim = 1'b1;
                end
            end
            LDC_DIRECT: begin
                // period restarts at each input edge to stay in step
                d.amp = AMP_FULL;
                per_sel = m_per;
                on_sel = m_high;
                restart = m_rise;
                pwm_dim = 1'b1;
            end
            default: begin
                // analog: strings stay on, amplitude carries the duty
                d.amp = duty;
                per_sel = FULL_ON;
                on_sel = FULL_ON;
                d.vled_hi = d100 < LOW_LIM;
            end
        endcase

        // short on time needs the output held near the threshold
        d.deep = pwm_dim && (on_sel < CNT_W'(DEEP_ON_CYC));

        // start-up window, then grounded pins are marked unused
        if (!q.started) begin
            if (q.scnt >= 24'(STARTUP_CYCLES - 1)) begin
                d.started = 1'b1;
                d.unused = q.sy2[11:6];
            end else begin
                d.scnt = q.scnt + 1'b1;
            end
        end

        // channel count enables from the lowest channel upward
        if (q.cfg1[CHCNT_LSB +: 3] > 3'd5) begin
            nch = 3'd6;
        end else begin
            nch = 3'd6 - q.cfg1[CHCNT_LSB +: 3];
        end
        en_mask = 6'h3f >> (3'd6 - nch);
        en_mask = q.started ? (en_mask & ~q.unused) : 6'h00;
        // assumes unused channels sit at the top of the range
        n_act = ldc_popcount(en_mask);

        shift_en = (q.cfg1[PSE_BIT]
                    || (q.sy2[4] && q.sy2[5]))
                   && pwm_dim;

        // channel one tracks the input itself in direct mode
        for (int k = 0; k < N_CH; k++) begin
            bits[k] = ph_on[k];
            if (mode == LDC_DIRECT && (k == 0 || !shift_en)) begin
                bits[k] = q.sy2[0];
            end
        end
        d.chan = bits & en_mask;

        // apb: answer is prepared in setup, ready in the access cycle
        setup = psel && !penable;
        addr_ok = (paddr == CFG0_ADDR) || (paddr == CFG1_ADDR)
                  || (paddr == STAT_ADDR);
        d.pready = setup;
        d.pslverr = setup && !addr_ok;
        d.prdata = '0;
        if (setup && !pwrite) begin
            unique case (paddr)
                CFG0_ADDR: d.prdata[7:0] = q.cfg0;
                CFG1_ADDR: d.prdata[7:0] = q.cfg1;
                STAT_ADDR: begin
                    d.prdata[ST_DUTY_LSB +: 10] = duty;
                    d.prdata[ST_MODE_LSB +: 2] = q.mode;
                    d.prdata[ST_START_BIT] = q.started;
                    d.prdata[ST_UNUSED_LSB +: 6] = q.unused;
                end
                default: d.prdata = '0;
            endcase
        end
        // writes land only at the completing access edge
        if (psel && penable && q.pready && pwrite && !q.pslverr) begin
            if (paddr == CFG0_ADDR) begin
                d.cfg0 = pwdata[7:0] & CFG0_MASK;
            end
            if (paddr == CFG1_ADDR) begin
                d.cfg1 = pwdata[7:0] & CFG1_MASK;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
            q.cfg0 <= CFG0_RST;
            q.cfg1 <= CFG1_RST;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign led_channel_on = q.chan;
    assign led_amplitude = q.amp;
    assign vled_min_raise = q.vled_hi;
    assign vout_deep_dim = q.deep;
    assign dimming_mode = q.mode;
endmodule

//--- sim/ldc_host_pwm.sv
// host-side dimming pwm source for the controller bench
module ldc_host_pwm (
    input  wire logic        clk, // bench clock
    input  wire logic [10:0] hi,  // high cycles per period, 0 = idle low
    output logic             pwm  // dimming pwm pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // 2048-cycle period is about 12 kHz, inside the analog band
    logic [10:0] cnt_q = 11'h000;

    // free-running period counter
    always @(posedge clk) begin
        cnt_q <= cnt_q + 11'h001;
    end
    // stays low until the bench has finished its register setup
    assign pwm = cnt_q < hi;
endmodule

//--- sim/ldc_checker.sv
// port assertions for the led dimming controller
module ldc_checker (
    input wire logic        clk,            // clock
    input wire logic        rst,            // sync reset
    input wire logic        psel,           // apb select
    input wire logic        penable,        // apb access
    input wire logic [31:0] prdata,         // apb read data
    input wire logic        pready,         // apb ready
    input wire logic        pslverr,        // apb error
    input wire logic        strap_low,      // strap low band
    input wire logic        strap_mid,      // strap mid band
    input wire logic        strap_high,     // strap high band
    input wire logic [9:0]  led_amplitude,  // current amplitude
    input wire logic        vled_min_raise, // led pin target up
    input wire logic        vout_deep_dim,  // deep dim regulation
    input wire logic [1:0]  dimming_mode    // mode in effect
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence

    // no wait states: the access cycle always completes
    AST_READY_AFTER_SETUP: assert property (s_setup |=> s_access)
        else $error("no ready after setup");
    AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    // straps pass a two-flop synchroniser before the mode register
    AST_STRAP_LOW_MIX: assert property (
        strap_low [*6] |-> dimming_mode == 2'b00)
        else $error("low strap not mix");
    AST_STRAP_MID_DIRECT: assert property (
        (!strap_low && strap_mid) [*6] |-> dimming_mode == 2'b01)
        else $error("mid strap not direct");
    AST_STRAP_HIGH_ANALOG: assert property (
        (!strap_low && !strap_mid && strap_high) [*6]
        |-> dimming_mode == 2'b10)
        else $error("high strap not analog");
    AST_DIRECT_FULL_AMP: assert property (
        (dimming_mode == 2'b01) [*4] |-> led_amplitude == 10'h3ff)
        else $error("direct mode amplitude not full");
    // one cycle of skew allowed between the mode and derived flags
    AST_RAISE_ANALOG: assert property (vled_min_raise |->
        dimming_mode == 2'b10 || $past(dimming_mode) == 2'b10)
        else $error("pin target raised outside analog");
    AST_DEEP_NOT_ANALOG: assert property (vout_deep_dim |->
        dimming_mode != 2'b10 || $past(dimming_mode) != 2'b10)
        else $error("deep dim during analog");
endmodule

bind ldc_dimming_ctrl ldc_checker u_chk (.clk, .rst, .psel, .penable,
    .prdata, .pready, .pslverr, .strap_low, .strap_mid, .strap_high,
    .led_amplitude, .vled_min_raise, .vout_deep_dim, .dimming_mode);

//--- sim/led_dimming_control_tb.sv
// self-checking bench for the led dimming controller
module led_dimming_control_tb import ldc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        dim_pwm_in;
    logic        strap_low = 1'b0;
    logic        strap_mid = 1'b0;
    logic        strap_high = 1'b0;
    logic        serial_clock_phase_strap = 1'b0;
    logic        serial_data_phase_strap = 1'b0;
    logic [5:0]  led_channel_pin_low = 6'h20;
    logic [5:0]  led_channel_on;
    logic [9:0]  led_amplitude;
    logic        vled_min_raise;
    logic        vout_deep_dim;
    logic [1:0]  dimming_mode;
    logic [10:0] pwm_hi = 11'h000;
    int          error_cnt = 0;
    int          cmp_count = 0;

    // short start-up so the channels come up quickly
    ldc_dimming_ctrl #(.STARTUP_CYCLES(20)) DUT (.clk, .rst, .paddr, .psel,
        .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .dim_pwm_in,
        .strap_low, .strap_mid, .strap_high, .serial_clock_phase_strap,
        .serial_data_phase_strap, .led_channel_pin_low, .led_channel_on,
        .led_amplitude, .vled_min_raise, .vout_deep_dim, .dimming_mode);
    ldc_host_pwm u_host (.clk, .hi(pwm_hi), .pwm(dim_pwm_in));

    // 40 ns clock
    always #20 clk = ~clk;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // one apb transfer; the request holds until ready is sampled
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) error_cnt++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, {24'h0, d}, r, e);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
        chk(32'(e), 32'(xe));
    endtask

    // the meter needs a full period before a new duty is valid
    task settle;
        repeat (3 * 2048) @(posedge clk);
    endtask

    task rise;
        do @(posedge clk); while (dim_pwm_in !== 1'b0);
        do @(posedge clk); while (dim_pwm_in !== 1'b1);
    endtask

    task t_regs;
        rd(CFG0_ADDR, 32'h0, 1'b0);
        rd(CFG1_ADDR, 32'h0, 1'b0);
        wr(STAT_ADDR, 8'hff);
        rd(STAT_ADDR, 32'h0020_4000, 1'b0);
        wr(CFG0_ADDR, 8'hff);
        rd(CFG0_ADDR, 32'h78, 1'b0);
        rd(8'h08, 32'h0, 1'b1);
    endtask

    task t_modes;
        for (int i = 0; i < 3; i++) begin
            wr(CFG0_ADDR, 8'(i << 5));
            repeat (6) @(posedge clk);
            chk(32'(dimming_mode), 32'(i));
        end
        strap_low <= 1'b1;
        repeat (8) @(posedge clk);
        chk(32'(dimming_mode), 32'h0);
        strap_low <= 1'b0;
        strap_mid <= 1'b1;
        repeat (8) @(posedge clk);
        chk(32'(dimming_mode), 32'h1);
        strap_mid <= 1'b0;
        strap_high <= 1'b1;
        wr(CFG0_ADDR, 8'h00);
        repeat (8) @(posedge clk);
        chk(32'(dimming_mode), 32'h2);
        strap_high <= 1'b0;
    endtask

    // four channels, windows of a quarter period each
    task t_phase(input logic strap);
        wr(CFG0_ADDR, 8'h20);
        wr(CFG1_ADDR, strap ? 8'h02 : 8'h82);
        serial_clock_phase_strap <= strap;
        serial_data_phase_strap <= strap;
        pwm_hi <= 11'd512;
        settle;
        rise;
        repeat (256) @(posedge clk);
        for (int k = 0; k < 4; k++) begin
            chk(32'(led_channel_on), 32'(6'h01 << k));
            repeat (512) @(posedge clk);
        end
        chk(32'(led_amplitude), 32'h3ff);
    endtask

    task t_direct;
        wr(CFG1_ADDR, 8'h05);
        serial_clock_phase_strap <= 1'b0;
        serial_data_phase_strap <= 1'b0;
        rise;
        repeat (256) @(posedge clk);
        chk(32'(led_channel_on), 32'h01);
        repeat (1024) @(posedge clk);
        chk(32'(led_channel_on), 32'h00);
    endtask

    task t_analog;
        int hv[3] = '{1024, 204, 10};
        int ax[3] = '{512, 102, 5};
        wr(CFG0_ADDR, 8'h40);
        wr(CFG1_ADDR, 8'h80);
        for (int i = 0; i < 3; i++) begin
            pwm_hi <= 11'(hv[i]);
            settle;
            chk(32'(led_amplitude), 32'(ax[i]));
            chk(32'(vled_min_raise), 32'(i > 0));
            chk(32'(led_channel_on), 32'h1f);
        end
    endtask

    // fast mix period keeps the on-time count short
    task t_mix;
        logic [7:0] cf[4] = '{8'h08, 8'h08, 8'h18, 8'h18};
        int         hv[4] = '{1024, 204, 204, 10};
        int         ax[4] = '{512, 256, 128, 128};
        int         ox[4] = '{1086, 432, 865, 42};
        int         n;
        wr(CFG1_ADDR, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(CFG0_ADDR, cf[i]);
            pwm_hi <= 11'(hv[i]);
            settle;
            n = 0;
            repeat (1086) begin
                @(posedge clk);
                n += int'(led_channel_on[0]);
            end
            chk(32'(led_amplitude), 32'(ax[i]));
            chk(32'(n >= ox[i] - 3 && n <= ox[i] + 3), 32'h1);
            chk(32'(vout_deep_dim), 32'(i == 3));
        end
    endtask

    task print_verdict;
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (30) @(posedge clk);
        t_regs;
        t_modes;
        t_phase(1'b0);
        t_phase(1'b1);
        t_direct;
        t_analog;
        t_mix;
        print_verdict;
    end

    // run needs about 75k cycles; cut off at 100k
    initial begin
        #4_000_000;
        error_cnt++;
        print_verdict;
    end
endmodule
